// ===== hdl/sdram_bank_state.sv
// Row state of one SDRAM bank: idle, open, or closing through the precharge time.
// Assumes activate only reaches an idle bank.
`timescale 1ns/10ps
module sdram_bank_state
	import sdram_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Commands
	input wire logic act_in,
	input wire logic pre_in,
	input wire logic [ROW_W-1:0] row_in,
	// State
	output logic open_out,
	output logic [ROW_W-1:0] row_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_OPEN = 3'b010,
		ST_CLOSING = 3'b100
	} bank_state_e;

	bank_state_e state;
	bank_state_e next_state;
	logic [3:0] wait_cnt;
	logic [3:0] next_wait_cnt;
	logic [ROW_W-1:0] next_row;

	always_comb begin
		next_state = state;
		next_wait_cnt = wait_cnt;
		next_row = row_out;
		case (state)
			ST_IDLE: begin
				if (act_in) begin
					next_state = ST_OPEN;
					next_row = row_in;
				end
			end
			ST_OPEN: begin
				if (pre_in) begin
					next_state = ST_CLOSING;
					next_wait_cnt = 4'(RP_CYC - 1);
				end
			end
			ST_CLOSING: begin
				if (wait_cnt == 4'h0) begin
					next_state = ST_IDLE;
				end else begin
					next_wait_cnt = wait_cnt - 4'h1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			wait_cnt <= 4'h0;
			row_out <= '0;
		end else begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			row_out <= next_row;
		end
	end

	assign open_out = (state == ST_OPEN);
endmodule : sdram_bank_state

// ===== hdl/sdram_ctrl_end.sv
// Controller end of the link: takes one operation at a time and drives SDRAM commands with legal spacing.
// Assumes the memory end shares the clock and runs the same burst and latency settings.
`timescale 1ns/10ps
module sdram_ctrl_end
	import sdram_pkg::*;
#(
	parameter int RAS_MAX = RAS_MAX_CYC
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Configuration
	input wire logic cas3_in,
	input wire logic [2:0] burst_code_in,
	// Operation request
	input wire logic op_valid_in,
	input wire logic [2:0] op_code_in,
	input wire logic op_bank_in,
	input wire logic [ROW_W-1:0] op_addr_in,
	input wire logic op_ap_in,
	output logic op_ready_out,
	output logic op_err_out,
	// Write data
	input wire logic [DQ_W-1:0] wr_data_in,
	input wire logic [1:0] wr_mask_in,
	output logic wr_take_out,
	// Read data
	output logic [DQ_W-1:0] rd_data_out,
	output logic rd_valid_out,
	// Link
	sdram_if.ctrl link
);
	logic [1:0] open;
	logic [13:0] ras_cnt [2];
	logic [3:0] act_wait [2];
	logic rd_act;
	logic rd_bank;
	logic rd_ap;
	logic rd_full;
	logic [8:0] rd_left;
	logic [1:0] sh;
	logic wr_act;
	logic wr_bank;
	logic wr_ap;
	logic wr_full;
	logic [8:0] wr_left;
	logic [1:0] mask_cnt;
	logic full_page;
	logic rd_busy;
	logic [1:0] over;
	logic ok;
	logic bad;
	logic take;
	logic go;
	cmd_e cmd;
	logic cmd_bank;
	logic cmd_all;
	logic mask_force;

	assign full_page = (burst_code_in == BL_FULL);
	assign rd_busy = rd_act || sh != 2'h0;
	assign over[0] = open[0] && ras_cnt[0] >= 14'(RAS_MAX);
	assign over[1] = open[1] && ras_cnt[1] >= 14'(RAS_MAX);

	////////////////////////////////////////////////////////////////////////////////
	// Acceptance and command choice
	always_comb begin
		ok = 1'b0;
		bad = 1'b0;
		case (op_code_in)
			OP_ACT: begin
				bad = open[op_bank_in];
				ok = act_wait[op_bank_in] == 4'h0;
			end
			OP_READ: begin
				bad = !open[op_bank_in];
				ok = ras_cnt[op_bank_in] >= 14'(RCD_CYC);
			end
			OP_WRITE: begin
				bad = !open[op_bank_in];
				ok = ras_cnt[op_bank_in] >= 14'(RCD_CYC) && (!rd_busy || mask_cnt == 2'h2);
			end
			OP_PRE: begin
				ok = (!open[0] || ras_cnt[0] >= 14'(RAS_MIN_CYC) || !(op_addr_in[ALL_BIT] || !op_bank_in))
					&& (!open[1] || ras_cnt[1] >= 14'(RAS_MIN_CYC) || !(op_addr_in[ALL_BIT] || op_bank_in));
			end
			OP_BST: ok = 1'b1;
			default: bad = 1'b1;
		endcase
		op_ready_out = over == 2'h0 && (bad || ok);
		take = op_valid_in && op_ready_out;
		go = take && !bad;
		op_err_out = take && bad;
		cmd = CMD_NOP;
		cmd_bank = op_bank_in;
		cmd_all = op_addr_in[ALL_BIT];
		if (over != 2'h0) begin
			cmd = CMD_PRE;
			cmd_bank = !over[0];
			cmd_all = 1'b0;
		end else if (go) begin
			case (op_code_in)
				OP_ACT: cmd = CMD_ACT;
				OP_READ: cmd = CMD_READ;
				OP_WRITE: cmd = CMD_WRITE;
				OP_PRE: cmd = CMD_PRE;
				OP_BST: cmd = CMD_BST;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link drive
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bst;
	logic rd_last;
	logic wr_last;
	logic wr_cut;

	assign is_rd = cmd == CMD_READ;
	assign is_wr = cmd == CMD_WRITE;
	assign is_pre = cmd == CMD_PRE;
	assign is_bst = cmd == CMD_BST;
	assign wr_cut = is_rd || is_bst || (is_pre && (cmd_all || cmd_bank == wr_bank));
	assign rd_last = rd_act && !rd_full && rd_left == 9'h1;
	assign wr_last = wr_take_out && (is_wr ? (!full_page && burst_len(burst_code_in) == 9'h1)
		: (!wr_full && wr_left == 9'h1));
	// bus released except on write words
	assign wr_take_out = is_wr || (wr_act && !wr_cut);
	assign mask_force = (op_valid_in && op_code_in == OP_WRITE && rd_busy && mask_cnt != 2'h2)
		|| (wr_act && is_pre && (cmd_all || cmd_bank == wr_bank));

	always_comb begin
		link.cs_n = cmd == CMD_NOP;
		{link.ras_n, link.cas_n, link.we_n} = cmd;
		link.addr = '0;
		link.addr[BANK_BIT] = cmd_bank;
		if (is_pre) begin
			link.addr[ALL_BIT] = cmd_all;
		end else if (is_rd || is_wr) begin
			link.addr[COL_W-1:0] = op_addr_in[COL_W-1:0];
			link.addr[AP_BIT] = op_ap_in;
		end else begin
			link.addr[ROW_W-1:0] = op_addr_in;
		end
		link.upper_lower_byte_masks = (mask_force ? 2'h3 : 2'h0) | (wr_take_out ? wr_mask_in : 2'h0);
		link.dq_ctrl = wr_data_in;
		link.dq_ctrl_oe = wr_take_out;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst mirrors and bank timers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			open <= 2'h0;
			ras_cnt <= '{14'h0, 14'h0};
			act_wait <= '{4'h0, 4'h0};
			{rd_act, rd_bank, rd_ap, rd_full, rd_left, sh} <= '0;
			{wr_act, wr_bank, wr_ap, wr_full, wr_left} <= '0;
			mask_cnt <= 2'h0;
			rd_data_out <= '0;
			rd_valid_out <= 1'b0;
		end else begin
			mask_cnt <= mask_force && mask_cnt != 2'h2 ? mask_cnt + 2'h1 : (mask_force ? mask_cnt : 2'h0);
			sh <= {sh[0], rd_act && !is_wr};
			rd_valid_out <= (cas3_in ? sh[1] : sh[0]);
			rd_data_out <= link.dq;
			for (int b = 0; b < 2; b++) begin
				if (ras_cnt[b] != 14'h3fff) ras_cnt[b] <= ras_cnt[b] + 14'h1;
				if (act_wait[b] != 4'h0) act_wait[b] <= act_wait[b] - 4'h1;
				if (cmd == CMD_ACT && cmd_bank == 1'(b)) begin
					open[b] <= 1'b1;
					ras_cnt[b] <= 14'h1;
				end
				if (is_pre && open[b] && (cmd_all || cmd_bank == 1'(b))) begin
					open[b] <= 1'b0;
					act_wait[b] <= 4'(RP_CYC);
				end
				if (rd_last && rd_ap && !is_rd && !is_wr && !is_bst && rd_bank == 1'(b)) begin
					open[b] <= 1'b0;
					act_wait[b] <= 4'(RP_CYC);
				end
				if (wr_last && (is_wr ? op_ap_in && !full_page : wr_ap) && (is_wr ? cmd_bank : wr_bank) == 1'(b)) begin
					open[b] <= 1'b0;
					act_wait[b] <= 4'(DAL_EXTRA_CYC + RP_CYC);
				end
			end
			if (is_rd) begin
				rd_act <= 1'b1;
				rd_bank <= cmd_bank;
				rd_left <= burst_len(burst_code_in);
				rd_full <= full_page;
				rd_ap <= op_ap_in && !full_page;
			end else if (is_wr || is_bst || (is_pre && (cmd_all || cmd_bank == rd_bank)) || rd_last) begin
				rd_act <= 1'b0;
			end else if (rd_act) begin
				rd_left <= rd_left - 9'h1;
			end
			if (is_wr) begin
				wr_act <= !wr_last;
				wr_bank <= cmd_bank;
				wr_left <= burst_len(burst_code_in) - 9'h1;
				wr_full <= full_page;
				wr_ap <= op_ap_in && !full_page;
			end else if (wr_cut || wr_last) begin
				wr_act <= 1'b0;
			end else if (wr_act) begin
				wr_left <= wr_left - 9'h1;
			end
		end
	end
endmodule : sdram_ctrl_end

// ===== hdl/sdram_mem_end.sv
// Memory end of the link: bank precharge, burst engines and burst termination of a two-bank SDRAM.
// Assumes the controller keeps its own timing; storage sits outside behind the array port.
`timescale 1ns/10ps
module sdram_mem_end
	import sdram_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Configuration
	input wire logic cas3_in,
	input wire logic [2:0] burst_code_in,
	// Link
	sdram_if.mem link,
	// Array port
	output logic arr_we_out,
	output logic [1:0] arr_byte_en_out,
	output logic arr_bank_out,
	output logic [ROW_W-1:0] arr_row_out,
	output logic [COL_W-1:0] arr_col_out,
	output logic [DQ_W-1:0] arr_wdata_out,
	input wire logic [DQ_W-1:0] arr_rdata_in,
	// Bank state
	output logic [1:0] bank_open_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Command decode
	cmd_e cmd;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bst;
	logic bank_select_line;
	logic precharge_all_line;
	logic full_page;

	always_comb begin
		cmd = link.cs_n ? CMD_NOP : cmd_e'({link.ras_n, link.cas_n, link.we_n});
	end

	assign is_act = (cmd == CMD_ACT);
	assign is_rd = (cmd == CMD_READ);
	assign is_wr = (cmd == CMD_WRITE);
	assign is_pre = (cmd == CMD_PRE);
	assign is_bst = (cmd == CMD_BST);
	assign bank_select_line = link.addr[BANK_BIT];
	assign precharge_all_line = link.addr[ALL_BIT];
	assign full_page = (burst_code_in == BL_FULL);

	////////////////////////////////////////////////////////////////////////////////
	// Bank state
	logic rd_act;
	logic rd_bank;
	logic [COL_W-1:0] rd_col;
	logic [8:0] rd_left;
	logic rd_full;
	logic rd_ap;
	logic wr_act;
	logic wr_bank;
	logic [COL_W-1:0] wr_col;
	logic [8:0] wr_left;
	logic wr_full;
	logic wr_ap;
	logic wr_ap_pend;
	logic rd_stop;
	logic wr_stop;
	logic rd_last;
	logic rd_ap_fire;
	logic [1:0] bank_act;
	logic [1:0] bank_pre;
	logic [ROW_W-1:0] bank_row [2];

	for (genvar b = 0; b < 2; b++) begin : g_bank
		assign bank_act[b] = is_act && (bank_select_line == 1'(b));
		assign bank_pre[b] = (is_pre && (precharge_all_line || bank_select_line == 1'(b)))
			|| (rd_ap_fire && rd_bank == 1'(b)) || (wr_ap_pend && wr_bank == 1'(b));
		sdram_bank_state u_bank (
			.core_clk_in(core_clk_in),
			.rst_n_in(rst_n_in),
			.act_in(bank_act[b]),
			.pre_in(bank_pre[b]),
			.row_in(link.addr[ROW_W-1:0]),
			.open_out(bank_open_out[b]),
			.row_out(bank_row[b])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read burst engine
	logic next_rd_act;
	logic next_rd_bank;
	logic [COL_W-1:0] next_rd_col;
	logic [8:0] next_rd_left;
	logic next_rd_full;
	logic next_rd_ap;

	// precharge on read bank stops engine
	assign rd_stop = is_wr || is_bst || (is_pre && (precharge_all_line || bank_select_line == rd_bank));
	assign rd_last = rd_act && !rd_full && rd_left == 9'h1;
	// precharge starts edge after last fetch
	assign rd_ap_fire = rd_last && rd_ap && !rd_stop && !is_rd;

	always_comb begin
		next_rd_act = rd_act;
		next_rd_bank = rd_bank;
		next_rd_col = rd_col;
		next_rd_left = rd_left;
		next_rd_full = rd_full;
		next_rd_ap = rd_ap;
		if (is_rd) begin
			next_rd_act = 1'b1;
			next_rd_bank = bank_select_line;
			next_rd_col = link.addr[COL_W-1:0];
			next_rd_left = burst_len(burst_code_in);
			next_rd_full = full_page;
			next_rd_ap = link.addr[AP_BIT] && !full_page;
		end else if (rd_stop || rd_last) begin
			next_rd_act = 1'b0;
		end else if (rd_act) begin
			next_rd_col = col_step(rd_col, burst_code_in);
			next_rd_left = rd_left - 9'h1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rd_act <= 1'b0;
			rd_bank <= 1'b0;
			rd_col <= '0;
			rd_left <= 9'h0;
			rd_full <= 1'b0;
			rd_ap <= 1'b0;
		end else begin
			rd_act <= next_rd_act;
			rd_bank <= next_rd_bank;
			rd_col <= next_rd_col;
			rd_left <= next_rd_left;
			rd_full <= next_rd_full;
			rd_ap <= next_rd_ap;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write burst engine
	logic wr_now;
	logic next_wr_act;
	logic next_wr_bank;
	logic [COL_W-1:0] next_wr_col;
	logic [8:0] next_wr_left;
	logic next_wr_full;
	logic next_wr_ap;
	logic next_wr_ap_pend;

	assign wr_stop = is_rd || is_bst || (is_pre && (precharge_all_line || bank_select_line == wr_bank));
	// write data taken on command clock
	assign wr_now = is_wr || (wr_act && !wr_stop);

	always_comb begin
		next_wr_act = wr_act;
		next_wr_bank = wr_bank;
		next_wr_col = wr_col;
		next_wr_left = wr_left;
		next_wr_full = wr_full;
		next_wr_ap = wr_ap;
		next_wr_ap_pend = 1'b0;
		if (is_wr) begin
			next_wr_bank = bank_select_line;
			next_wr_col = col_step(link.addr[COL_W-1:0], burst_code_in);
			next_wr_left = burst_len(burst_code_in) - 9'h1;
			next_wr_full = full_page;
			next_wr_ap = link.addr[AP_BIT] && !full_page;
			next_wr_act = full_page || burst_len(burst_code_in) != 9'h1;
			next_wr_ap_pend = !next_wr_act && next_wr_ap;
		end else if (wr_stop) begin
			next_wr_act = 1'b0;
		end else if (wr_act) begin
			if (!wr_full && wr_left == 9'h1) begin
				next_wr_act = 1'b0;
				// precharge one clock after last word
				next_wr_ap_pend = wr_ap;
			end else begin
				next_wr_col = col_step(wr_col, burst_code_in);
				next_wr_left = wr_left - 9'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wr_act <= 1'b0;
			wr_bank <= 1'b0;
			wr_col <= '0;
			wr_left <= 9'h0;
			wr_full <= 1'b0;
			wr_ap <= 1'b0;
			wr_ap_pend <= 1'b0;
		end else begin
			wr_act <= next_wr_act;
			wr_bank <= next_wr_bank;
			wr_col <= next_wr_col;
			wr_left <= next_wr_left;
			wr_full <= next_wr_full;
			wr_ap <= next_wr_ap;
			wr_ap_pend <= next_wr_ap_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Array port; engines never run together, so one address serves both
	always_comb begin
		arr_we_out = wr_now;
		arr_byte_en_out = ~link.upper_lower_byte_masks;
		arr_wdata_out = link.dq;
		if (is_wr) begin
			arr_bank_out = bank_select_line;
			arr_col_out = link.addr[COL_W-1:0];
		end else if (wr_act) begin
			arr_bank_out = wr_bank;
			arr_col_out = wr_col;
		end else begin
			arr_bank_out = rd_bank;
			arr_col_out = rd_col;
		end
		arr_row_out = bank_row[arr_bank_out];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output pipe: CAS latency 2 loads the output stage straight from the array
	logic stage_v;
	logic [DQ_W-1:0] stage_d;
	logic out_v;
	logic [DQ_W-1:0] out_d;
	logic [1:0] mask_q;
	logic next_stage_v;
	logic next_out_v;
	logic [DQ_W-1:0] next_out_d;
	logic [1:0] next_oe;

	always_comb begin
		// Write flushes pending read words so the bus is free for input
		next_stage_v = rd_act && !is_wr;
		next_out_v = (cas3_in ? stage_v : rd_act) && !is_wr;
		next_out_d = cas3_in ? stage_d : arr_rdata_in;
		// Masks act two clocks late on reads
		next_oe = {2{next_out_v}} & ~mask_q;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			stage_v <= 1'b0;
			stage_d <= '0;
			out_v <= 1'b0;
			out_d <= '0;
			mask_q <= 2'h0;
			link.dq_mem_oe <= 2'h0;
		end else begin
			stage_v <= next_stage_v;
			stage_d <= arr_rdata_in;
			out_v <= next_out_v;
			out_d <= next_out_d;
			mask_q <= link.upper_lower_byte_masks;
			link.dq_mem_oe <= next_oe;
		end
	end

	assign link.dq_mem = out_d;
endmodule : sdram_mem_end

// ===== shared/sdram_if.sv
// Pin-level link between the SDRAM model and its controller.
// Assumes both ends run on the same clock; the data bus is resolved here from the enables.
`timescale 1ns/10ps
interface sdram_if;
	import sdram_pkg::*;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [ADDR_W-1:0] addr;
	logic [1:0] upper_lower_byte_masks;
	logic [DQ_W-1:0] dq_ctrl;
	logic dq_ctrl_oe;
	logic [DQ_W-1:0] dq_mem;
	logic [1:0] dq_mem_oe;
	logic [DQ_W-1:0] dq;

	// Undriven lanes read as zero
	assign dq[7:0] = dq_mem_oe[0] ? dq_mem[7:0] : (dq_ctrl_oe ? dq_ctrl[7:0] : 8'h00);
	assign dq[15:8] = dq_mem_oe[1] ? dq_mem[15:8] : (dq_ctrl_oe ? dq_ctrl[15:8] : 8'h00);

	modport mem (
		input cs_n, ras_n, cas_n, we_n, addr, upper_lower_byte_masks, dq,
		output dq_mem, dq_mem_oe
	);
	modport ctrl (
		output cs_n, ras_n, cas_n, we_n, addr, upper_lower_byte_masks, dq_ctrl, dq_ctrl_oe,
		input dq
	);
endinterface : sdram_if

// ===== shared/sdram_pkg.sv
// Shared constants, command codes and column helpers for the two-bank SDRAM model and its controller.
// Assumes a single 100 MHz clock shared by both ends.
package sdram_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_NS = 10;
	localparam int T_RP_NS = 20;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RCD_NS = 20;
	localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RAS_MIN_NS = 42;
	localparam int RAS_MIN_CYC = (T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RAS_MAX_NS = 100000;
	localparam int RAS_MAX_CYC = T_RAS_MAX_NS / CLK_NS;
	// Extra clocks of write_autoprecharge_to_active beyond the row precharge time
	localparam int DAL_EXTRA_CYC = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and address fields
	localparam int ADDR_W = 12;
	localparam int DQ_W = 16;
	localparam int COL_W = 8;
	localparam int ROW_W = 11;
	localparam int AP_BIT = 10;
	localparam int ALL_BIT = 10;
	localparam int BANK_BIT = 11;
	localparam int FULL_PAGE_LEN = 256;
	localparam logic [2:0] BL_FULL = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Command codes {row strobe, column strobe, write enable}, all active low
	typedef enum logic [2:0] {
		CMD_ACT = 3'h3,
		CMD_READ = 3'h5,
		CMD_WRITE = 3'h4,
		CMD_PRE = 3'h2,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} cmd_e;

	typedef enum logic [2:0] {
		OP_ACT = 3'h0,
		OP_READ = 3'h1,
		OP_WRITE = 3'h2,
		OP_PRE = 3'h3,
		OP_BST = 3'h4
	} op_e;

	////////////////////////////////////////////////////////////////////////////////
	// Burst helpers; reserved codes run a full 256-word burst that ends
	function automatic logic [8:0] burst_len(input logic [2:0] code);
		case (code)
			3'h0: return 9'h1;
			3'h1: return 9'h2;
			3'h2: return 9'h4;
			3'h3: return 9'h8;
			default: return 9'(FULL_PAGE_LEN);
		endcase
	endfunction : burst_len

	// Sequential step, wrapping inside the burst-aligned block
	function automatic logic [7:0] col_step(input logic [7:0] col, input logic [2:0] code);
		logic [7:0] m;
		m = 8'(burst_len(code) - 9'h1);
		return (col & ~m) | ((col + 8'h1) & m);
	endfunction : col_step

endpackage : sdram_pkg

// ===== verification/sdram_link_assertions.sv
// Checks on the link between the memory end and the controller end.
// Assumes one clock; the bench wires it beside the link.
`timescale 1ns/10ps
module sdram_link_assertions
	import sdram_pkg::*;
(
	// Clock, reset, configuration
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic cas3_in,
	input wire logic [2:0] burst_code_in,
	// Link
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0] upper_lower_byte_masks,
	input wire logic dq_ctrl_oe,
	input wire logic [1:0] dq_mem_oe,
	// Bank state
	input wire logic [1:0] bank_open_out
);
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [2:0] cmd;
	assign cmd = cs_n ? 3'h7 : {ras_n, cas_n, we_n};
	////////////////////////////////////////
	sequence s_rd;
		cmd == CMD_READ;
	endsequence
	// Column command to bank 0 asking for autoprecharge
	sequence s_ap0;
		(cmd == CMD_READ || cmd == CMD_WRITE) && addr[AP_BIT] && !addr[BANK_BIT];
	endsequence
	AST_RD_LATENCY: assert property (s_rd ##0 !cas3_in && upper_lower_byte_masks == 2'b00
		##1 cmd != CMD_WRITE |=> dq_mem_oe == 2'b11) else $error("read data late");
	AST_RD_MASK: assert property (upper_lower_byte_masks == 2'b11 |-> ##2 dq_mem_oe == 2'b00)
		else $error("masked output driven");
	AST_CTRL_RELEASE: assert property (s_rd |=> !dq_ctrl_oe) else $error("bus held after read");
	// Released two clocks later at latency 2, three at latency 3
	AST_BST_FREE: assert property (cmd == CMD_BST ##1 cmd != CMD_READ
		|=> (cas3_in || dq_mem_oe == 2'b00) ##1 dq_mem_oe == 2'b00) else $error("bus not released");
	AST_PRE_ALL: assert property (cmd == CMD_PRE && addr[ALL_BIT] |=> bank_open_out == 2'b00)
		else $error("bank left open");
	AST_PRE_ONE: assert property (cmd == CMD_PRE && !addr[ALL_BIT] && !addr[BANK_BIT]
		|=> !bank_open_out[0] && $stable(bank_open_out[1])) else $error("wrong bank closed");
	AST_AP_CLOSE: assert property (s_ap0 ##0 burst_code_in == 3'h2
		|=> bank_open_out[0] [*4] ##1 !bank_open_out[0]) else $error("autoprecharge timing");
	AST_AP_FULL: assert property (s_ap0 ##0 burst_code_in == BL_FULL |=> bank_open_out[0] [*8])
		else $error("full page closed bank");
endmodule : sdram_link_assertions

// ===== verification/tb.sv
// Bench joining both ends over the link, with a small storage array.
// Assumes a 100 MHz clock and synchronous active-low reset.
`timescale 1ns/10ps
module tb;
	import sdram_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cas3_in = 1'b0;
	logic [2:0] burst_code_in = 3'h2;
	logic op_valid_in = 1'b0;
	logic op_bank_in = 1'b0;
	logic op_ap_in = 1'b0;
	logic [2:0] op_code_in = 3'h0;
	logic [ROW_W-1:0] op_addr_in = '0;
	logic [DQ_W-1:0] wr_data_in = 16'h1000;
	logic op_ready_out, op_err_out, wr_take_out, rd_valid_out, arr_we_out, arr_bank_out;
	logic [1:0] arr_byte_en_out, bank_open_out;
	logic [COL_W-1:0] arr_col_out;
	logic [DQ_W-1:0] rd_data_out, arr_wdata_out, arr_rdata_in;
	logic [DQ_W-1:0] mem [2][256];
	logic [DQ_W-1:0] got [$];
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int t0, t1, p;
	sdram_if link ();
	sdram_mem_end u_sdram_mem_end (.core_clk_in, .rst_n_in, .cas3_in, .burst_code_in, .link(link.mem), .arr_we_out,
		.arr_byte_en_out, .arr_bank_out, .arr_row_out(), .arr_col_out, .arr_wdata_out, .arr_rdata_in, .bank_open_out);
	sdram_ctrl_end #(.RAS_MAX(1000)) u_sdram_ctrl_end (.core_clk_in, .rst_n_in, .cas3_in, .burst_code_in,
		.op_valid_in, .op_code_in, .op_bank_in, .op_addr_in, .op_ap_in, .op_ready_out, .op_err_out, .wr_data_in,
		.wr_mask_in(2'b00), .wr_take_out, .rd_data_out, .rd_valid_out, .link(link.ctrl));
	sdram_link_assertions u_chk (.core_clk_in, .rst_n_in, .cas3_in, .burst_code_in, .cs_n(link.cs_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr), .dq_ctrl_oe(link.dq_ctrl_oe),
		.upper_lower_byte_masks(link.upper_lower_byte_masks), .dq_mem_oe(link.dq_mem_oe), .bank_open_out);
	always #5 core_clk_in = ~core_clk_in;
	////////////////////////////////////////
	// Storage answers in the same cycle; row is ignored
	assign arr_rdata_in = mem[arr_bank_out][arr_col_out];
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 2; i++)
			if (arr_we_out && arr_byte_en_out[i])
				mem[arr_bank_out][arr_col_out][i*8 +: 8] <= arr_wdata_out[i*8 +: 8];
		if (wr_take_out)
			wr_data_in <= wr_data_in + 16'h1;
		if (rd_valid_out)
			got.push_back(rd_data_out);
		if (cyc > 3000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic exp_rd(input int base, input logic b, input logic [7:0] col, input int n);
		for (int k = 0; k < n; k++)
			chk(got[base+k], mem[b][8'(col+k)]);
	endtask : exp_rd
	task automatic op(input logic [2:0] c, input logic b, input logic [ROW_W-1:0] a, input logic ap);
		op_valid_in <= 1'b1;
		op_code_in <= c;
		op_bank_in <= b;
		op_addr_in <= a;
		op_ap_in <= ap;
		@(negedge core_clk_in);
		while (op_ready_out !== 1'b1)
			@(negedge core_clk_in);
		@(posedge core_clk_in);
		t0 = t1;
		t1 = cyc;
	endtask : op
	task automatic idle(input int n);
		op_valid_in <= 1'b0;
		repeat (n) @(posedge core_clk_in);
	endtask : idle
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		for (int i = 0; i < 512; i++)
			mem[i[8]][i[7:0]] = 16'(i);
		repeat (5) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		idle(2);
		op(OP_ACT, 1'b0, 11'h001, 1'b0);
		op(OP_ACT, 1'b1, 11'h002, 1'b0);
		op(OP_WRITE, 1'b0, 11'h004, 1'b0);
		op(OP_READ, 1'b0, 11'h004, 1'b0);
		idle(12);
		// Read cuts the write after its first word
		chk(mem[0][4], 16'h1000);
		for (int k = 1; k < 4; k++)
			chk(mem[0][4+k], 16'(4 + k));
		exp_rd(0, 1'b0, 8'h04, 4);
		got.delete();
		op(OP_READ, 1'b0, 11'h000, 1'b0);
		op(OP_READ, 1'b0, 11'h008, 1'b0);
		idle(12);
		p = t1 - t0;
		chk(16'(got.size()), 16'(p + 4));
		exp_rd(0, 1'b0, 8'h00, p);
		exp_rd(p, 1'b0, 8'h08, 4);
		got.delete();
		// Interrupted burst yields one word per clock of lead
		op(OP_READ, 1'b1, 11'h000, 1'b0);
		op(OP_PRE, 1'b1, 11'h000, 1'b0);
		idle(12);
		chk(16'(got.size()), 16'(t1 - t0));
		exp_rd(0, 1'b1, 8'h00, t1 - t0);
		op(OP_WRITE, 1'b0, 11'h010, 1'b0);
		op(OP_WRITE, 1'b0, 11'h018, 1'b0);
		idle(6);
		p = t1 - t0;
		chk(mem[0][16], 16'h1001);
		chk(mem[0][8'(16 + p)], 16'(16 + p));
		for (int k = 0; k < 4; k++)
			chk(mem[0][24+k], 16'(16'h1001 + p + k));
		// Write after read: masks held two clocks first
		op(OP_READ, 1'b0, 11'h040, 1'b0);
		op(OP_WRITE, 1'b0, 11'h044, 1'b0);
		idle(6);
		for (int k = 0; k < 4; k++)
			chk(mem[0][68+k], 16'(16'h1006 + k));
		op(OP_WRITE, 1'b0, 11'h050, 1'b0);
		op(OP_PRE, 1'b0, 11'h000, 1'b0);
		idle(2);
		chk(mem[0][80], 16'h100a);
		chk(mem[0][81], 16'h0051);
		op(OP_ACT, 1'b0, 11'h001, 1'b0);
		op(OP_READ, 1'b0, 11'h000, 1'b1);
		idle(10);
		chk(16'(bank_open_out), 16'h0000);
		op(OP_ACT, 1'b0, 11'h001, 1'b0);
		op(OP_WRITE, 1'b0, 11'h020, 1'b1);
		idle(10);
		chk(16'(bank_open_out), 16'h0000);
		op(OP_PRE, 1'b0, 11'h000, 1'b0);
		idle(2);
		chk(16'(bank_open_out), 16'h0000);
		op(OP_ACT, 1'b0, 11'h001, 1'b0);
		op(OP_ACT, 1'b1, 11'h002, 1'b0);
		idle(6);
		op(OP_PRE, 1'b0, 11'h400, 1'b0);
		idle(2);
		chk(16'(bank_open_out), 16'h0000);
		got.delete();
		cas3_in <= 1'b1;
		burst_code_in <= BL_FULL;
		op(OP_ACT, 1'b0, 11'h001, 1'b0);
		op(OP_READ, 1'b0, 11'h0fa, 1'b1);
		idle(270);
		op(OP_BST, 1'b0, 11'h000, 1'b0);
		idle(8);
		chk(16'(bank_open_out[0]), 16'h0001);
		chk(16'(got.size()), 16'(t1 - t0));
		exp_rd(0, 1'b0, 8'hfa, 260);
		print_verdict();
	end
endmodule : tb
